// File: core/sdc_core.v
`timescale 1ns/1ns
`default_nettype none
`include "sdc_defs.vh"

module sdc_core (
    input  wire        sys_clk,
    input  wire        rstn,
    input  wire        clock_gate_input,
    input  wire        select_n_input,
    input  wire        row_strobe_n,
    input  wire        col_strobe_n,
    input  wire        write_strobe_n,
    input  wire [1:0]  bank_select,
    input  wire [12:0] addr,
    input  wire        byte_mask,
    input  wire [7:0]  data_lines_in,
    output reg  [7:0]  data_lines_out,
    output reg         data_lines_oe,
    output reg  [3:0]  bank_open,
    output reg         mode_valid,
    output reg  [12:0] mode_fields,
    output reg         burst_active,
    output reg         power_down,
    output reg         clock_suspend,
    output reg         self_refresh,
    output reg  [12:0] refresh_column_first
);

    // ****************************************************************
    // Local constants and helpers
    // ****************************************************************
    localparam [3:0] ST_RUN   = `SDC_ST_RUN;
    localparam [3:0] ST_PDOWN = `SDC_ST_PDOWN;
    localparam [3:0] ST_SUSP  = `SDC_ST_SUSP;
    localparam [3:0] ST_SREF  = `SDC_ST_SREF;

    // Burst length in beats from the length code
    function [11:0] burst_len;
        input [2:0] code;
        begin
            case (code)
                `SDC_BL_1:    burst_len = 12'h001;
                `SDC_BL_2:    burst_len = 12'h002;
                `SDC_BL_4:    burst_len = 12'h004;
                `SDC_BL_8:    burst_len = 12'h008;
                `SDC_BL_FULL: burst_len = `SDC_PAGE_LEN;
                default:      burst_len = 12'h001;
            endcase
        end
    endfunction

    // Column of beat n: wraps inside the block that the length defines
    function [10:0] beat_col;
        input [10:0] start;
        input [10:0] n;
        input [2:0]  code;
        input        inter;
        reg   [10:0] m;
        reg   [10:0] s;
        reg   [11:0] l;
        begin
            // Full page mask needs all eleven column bits, so cut after the subtraction
            l = burst_len(code) - 12'h001;
            m = l[10:0];
            s = start + n;
            if (inter && code != `SDC_BL_FULL) begin
                beat_col = (start & ~m) | ((start ^ n) & m);
            end else begin
                beat_col = (start & ~m) | (s & m);
            end
        end
    endfunction

    // ****************************************************************
    // Reset release through two flip-flops
    // ****************************************************************
    reg  [1:0] rst_sync_q;
    wire       rst_n_int = rst_sync_q[1];

    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    // ****************************************************************
    // Command decode
    // ****************************************************************
    reg         cke_prev_q;
    reg  [3:0]  st_q;
    reg  [3:0]  st_d;
    wire [2:0]  cmd      = {row_strobe_n, col_strobe_n, write_strobe_n};
    wire        sel      = !select_n_input;
    wire        is_nop   = select_n_input || cmd == `SDC_CMD_NOP;
    // Only edges after a high clock gate level are live; a low one freezes all but the power state machine
    wire        live     = cke_prev_q && st_q == ST_RUN;
    wire        c_act    = live && sel && cmd == `SDC_CMD_ACT;
    wire        c_pre    = live && sel && cmd == `SDC_CMD_PRE;
    wire        c_wr     = live && sel && cmd == `SDC_CMD_WR;
    wire        c_rd     = live && sel && cmd == `SDC_CMD_RD;
    wire        c_mrs    = live && sel && cmd == `SDC_CMD_MRS;
    wire        c_bst    = live && sel && cmd == `SDC_CMD_BST;
    wire        c_ref    = live && sel && cmd == `SDC_CMD_REF && clock_gate_input;
    wire        c_sref   = live && sel && cmd == `SDC_CMD_REF && !clock_gate_input;
    wire [10:0] cmd_col  = {addr[11], addr[9:0]};
    wire        ap_flag  = addr[`SDC_AP_BIT];

    // ****************************************************************
    // Burst engine
    // ****************************************************************
    reg  [10:0] start_q;
    reg  [10:0] cnt_q;
    reg  [11:0] len_q;
    reg  [1:0]  bbank_q;
    reg         bwr_q;
    reg         bap_q;
    reg  [12:0] row_q [0:3];

    wire [2:0]  bl_code  = mode_fields[`SDC_BL_MSB:`SDC_BL_LSB];
    wire        inter    = mode_fields[`SDC_BT_BIT];
    wire        single   = mode_fields[`SDC_OM_MSB:`SDC_OM_LSB] == `SDC_OM_SINGLE;
    wire        is_full  = bl_code == `SDC_BL_FULL;
    // Single-write mode shortens write bursts only
    wire [11:0] new_len  = (c_wr && single) ? 12'h001 : burst_len(bl_code);
    wire        new_cmd  = c_rd || c_wr;
    wire        cont     = live && burst_active && !new_cmd && !c_bst;

    reg         acc_valid;
    reg         acc_wr;
    reg  [1:0]  acc_bank;
    reg  [10:0] acc_col;
    reg         acc_last;
    reg         acc_ap;

    always @* begin
        acc_valid = new_cmd || cont;
        acc_wr    = new_cmd ? c_wr : bwr_q;
        acc_bank  = new_cmd ? bank_select : bbank_q;
        acc_ap    = new_cmd ? ap_flag : bap_q;
        acc_col   = new_cmd ? cmd_col : beat_col(start_q, cnt_q, bl_code, inter);
        if (new_cmd) begin
            acc_last = new_len == 12'h001;
        end else begin
            // Full page never ends by itself
            acc_last = !(is_full && len_q == `SDC_PAGE_LEN) && ({1'b0, cnt_q} + 12'h001 == len_q);
        end
    end

    // ****************************************************************
    // Power state machine
    // ****************************************************************
    always @* begin
        st_d = st_q;
        case (st_q)
            ST_RUN: begin
                if (cke_prev_q && !clock_gate_input) begin
                    if (c_sref) begin
                        st_d = ST_SREF;
                    end else if (burst_active && !(acc_valid && acc_last)) begin
                        st_d = ST_SUSP;
                    end else begin
                        st_d = ST_PDOWN;
                    end
                end
            end
            ST_PDOWN, ST_SREF: begin
                if (clock_gate_input && is_nop) begin
                    st_d = ST_RUN;
                end
            end
            ST_SUSP: begin
                if (clock_gate_input) begin
                    st_d = ST_RUN;
                end
            end
            default: st_d = ST_RUN;
        endcase
    end

    // ****************************************************************
    // Control registers
    // ****************************************************************
    integer i;

    always @(posedge sys_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            cke_prev_q           <= 1'b0;
            st_q                 <= ST_RUN;
            mode_fields          <= `SDC_MODE_RST;
            mode_valid           <= 1'b0;
            bank_open            <= 4'h0;
            burst_active         <= 1'b0;
            start_q              <= 11'h000;
            cnt_q                <= 11'h000;
            len_q                <= 12'h001;
            bbank_q              <= 2'h0;
            bwr_q                <= 1'b0;
            bap_q                <= 1'b0;
            refresh_column_first <= 13'h0000;
            power_down           <= 1'b0;
            clock_suspend        <= 1'b0;
            self_refresh         <= 1'b0;
            for (i = 0; i < 4; i = i + 1) begin
                row_q[i] <= 13'h0000;
            end
        end else begin
            cke_prev_q    <= clock_gate_input;
            st_q          <= st_d;
            power_down    <= st_d == ST_PDOWN;
            clock_suspend <= st_d == ST_SUSP;
            self_refresh  <= st_d == ST_SREF;
            // Mode fields change only here, so refresh and low power keep them
            if (c_mrs) begin
                mode_fields <= addr;
                mode_valid  <= 1'b1;
            end
            if (c_act) begin
                bank_open[bank_select] <= 1'b1;
                row_q[bank_select]     <= addr;
            end
            if (c_ref || c_sref) begin
                refresh_column_first <= refresh_column_first + 13'h0001;
            end
            if (new_cmd) begin
                start_q <= cmd_col;
                cnt_q   <= 11'h001;
                len_q   <= new_len;
                bbank_q <= bank_select;
                bwr_q   <= c_wr;
                bap_q   <= ap_flag;
            end else if (cont) begin
                cnt_q <= cnt_q + 11'h001;
            end
            if (acc_valid) begin
                burst_active <= !acc_last;
                if (acc_last && acc_ap) begin
                    bank_open[acc_bank] <= 1'b0;
                end
            end else if (c_bst) begin
                burst_active <= 1'b0;
            end
            if (c_pre) begin
                if (ap_flag) begin
                    bank_open    <= 4'h0;
                    burst_active <= 1'b0;
                end else begin
                    bank_open[bank_select] <= 1'b0;
                    if (bank_select == bbank_q) begin
                        burst_active <= 1'b0;
                    end
                end
            end
        end
    end

    // ****************************************************************
    // Storage and read latency pipe
    // ****************************************************************
    // Only a small window of each page is kept: bank and low column bits
    reg  [7:0] mem [0:255];
    reg  [7:0] pipe0_q;
    reg  [7:0] pipe1_q;
    reg  [1:0] pv_q;
    wire [7:0] idx     = {acc_bank, acc_col[5:0]};
    wire       cl3     = mode_fields[`SDC_CL_MSB:`SDC_CL_LSB] == `SDC_CL_3;
    wire       hold    = !cke_prev_q; // Suspended edges freeze the pipe too

    always @(posedge sys_clk) begin
        if (acc_valid && acc_wr && !byte_mask) begin
            mem[idx] <= data_lines_in;
        end
        if (!hold) begin
            pipe0_q <= mem[idx];
            pipe1_q <= pipe0_q;
        end
    end

    always @(posedge sys_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            pv_q           <= 2'h0;
            data_lines_out <= 8'h00;
            data_lines_oe  <= 1'b0;
        end else if (!hold) begin
            // A masked read beat still advances but never drives the lines
            pv_q[0] <= acc_valid && !acc_wr && !byte_mask;
            pv_q[1] <= pv_q[0];
            if (cl3) begin
                data_lines_out <= pipe1_q;
                data_lines_oe  <= pv_q[1];
            end else begin
                data_lines_out <= pipe0_q;
                data_lines_oe  <= pv_q[0];
            end
        end
    end

endmodule // sdc_core
`default_nettype wire

// File: core/sdc_defs.vh
// What this block does
// - All inputs but rstn captured and read data launched on rising sys_clk edge only; rstn low resets at once.
// - Clock gate low ignores clock edges; enters power down, suspend or self refresh.
// - Two bank_select bits pick one of four banks for bank commands.
// - Activate takes the thirteen address bits as the bank's row.
// - Read and write take column bits 0-9 and 11, a 2048-column page.
// - Read or write with precharge_flag_bit high closes the bank after the burst.
// - Precharge closes all banks when precharge_flag_bit high, else only the named bank.
// - Select low plus row/column/write strobe levels decode the command set.
// - Clock gate commands decode from previous and current clock gate levels.
// - Clock gate low during a running burst gives clock suspend; low on a read or write that starts a burst from idle gives power down.
// - Byte mask high blocks write storage and read data drive.
// - Mode register holds no valid setting until first mode register set.
// - Mode set precedes first activate; later mode sets replace stored fields.
// - Mode set loads the fields from the address inputs at that edge.
// - Burst length codes 000/001/010/011 give 1/2/4/8; 111 full page, sequential only.
// - Bit 3 picks burst order; zero is sequential.
// - Operation mode picks burst writes or single-word writes with burst reads.
// - Latency bits 6-4: 010 gives two clocks, 011 three; others reserved.
// - Operation mode bits 12-7: zero burst write, one single write.
`ifndef SDC_DEFS_VH
`define SDC_DEFS_VH

// ****************************************************************
// Command codes as {row strobe, column strobe, write strobe}
// ****************************************************************
`define SDC_CMD_ACT     3'h3
`define SDC_CMD_PRE     3'h2
`define SDC_CMD_WR      3'h4
`define SDC_CMD_RD      3'h5
`define SDC_CMD_MRS     3'h0
`define SDC_CMD_NOP     3'h7
`define SDC_CMD_BST     3'h6
`define SDC_CMD_REF     3'h1

// ****************************************************************
// Mode register fields
// ****************************************************************
`define SDC_MODE_W      13
`define SDC_MODE_RST    13'h0000
`define SDC_BL_MSB      2
`define SDC_BL_LSB      0
`define SDC_BT_BIT      3
`define SDC_CL_MSB      6
`define SDC_CL_LSB      4
`define SDC_OM_MSB      12
`define SDC_OM_LSB      7
`define SDC_BL_1        3'h0
`define SDC_BL_2        3'h1
`define SDC_BL_4        3'h2
`define SDC_BL_8        3'h3
`define SDC_BL_FULL     3'h7
`define SDC_CL_2        3'h2
`define SDC_CL_3        3'h3
`define SDC_OM_SINGLE   6'h01
`define SDC_PAGE_LEN    12'h800
`define SDC_AP_BIT      10

// ****************************************************************
// Power states, one-hot
// ****************************************************************
`define SDC_ST_RUN      4'h1
`define SDC_ST_PDOWN    4'h2
`define SDC_ST_SUSP     4'h4
`define SDC_ST_SREF     4'h8

`endif

// File: verification/sdc_core_assertions.sv
`timescale 1ns/1ns
`default_nettype none
`include "sdc_defs.vh"
// ****************
// Port checker
// ****************
module sdc_core_chk (
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic        clock_gate_input,
    input wire logic        select_n_input,
    input wire logic        row_strobe_n,
    input wire logic        col_strobe_n,
    input wire logic        write_strobe_n,
    input wire logic [1:0]  bank_select,
    input wire logic [12:0] addr,
    input wire logic        byte_mask,
    input wire logic [7:0]  data_lines_in,
    input wire logic [7:0]  data_lines_out,
    input wire logic        data_lines_oe,
    input wire logic [3:0]  bank_open,
    input wire logic        mode_valid,
    input wire logic [12:0] mode_fields,
    input wire logic        burst_active,
    input wire logic        power_down,
    input wire logic        clock_suspend,
    input wire logic        self_refresh,
    input wire logic [12:0] refresh_column_first
);
    logic [1:0] up_q;
    logic       gate_q;
    logic       run;
    logic       live;
    logic [2:0] cmd;
    // Mirrors the two-flop reset copy, so no command is judged too early
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            up_q   <= 2'h0;
            gate_q <= 1'h0;
        end else begin
            up_q   <= {up_q[0], 1'h1};
            gate_q <= up_q[1] && clock_gate_input;
        end
    end
    assign run  = up_q[1] && gate_q && !power_down && !clock_suspend && !self_refresh;
    assign live = run && !select_n_input;
    assign cmd  = {row_strobe_n, col_strobe_n, write_strobe_n};
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    AST_MODE_LOAD: assert property (live && cmd == `SDC_CMD_MRS
        |=> mode_valid && mode_fields == $past(addr)) else $error("mode load wrong");
    AST_MODE_HOLD: assert property (!(live && cmd == `SDC_CMD_MRS)
        |=> $stable(mode_fields)) else $error("mode changed");
    AST_ACT_OPEN: assert property (live && cmd == `SDC_CMD_ACT
        |=> bank_open[$past(bank_select)]) else $error("bank not opened");
    AST_PRE_ALL: assert property (live && cmd == `SDC_CMD_PRE && addr[10]
        |=> bank_open == 4'h0) else $error("banks left open");
    AST_PRE_ONE: assert property (live && cmd == `SDC_CMD_PRE && !addr[10]
        |=> !bank_open[$past(bank_select)]) else $error("named bank left open");
    AST_RD_DRIVE: assert property (live && cmd == `SDC_CMD_RD && !byte_mask
        && mode_fields[6:4] != 3'h3 && clock_gate_input |-> ##2 data_lines_oe) else $error("no read data");
    AST_RD_MASK: assert property (live && cmd == `SDC_CMD_RD && byte_mask
        && mode_fields[6:4] != 3'h3 && clock_gate_input |-> ##2 !data_lines_oe) else $error("mask ignored");
    AST_PDOWN: assert property (run && !clock_gate_input && select_n_input
        && bank_open == 4'h0 && !burst_active |=> power_down) else $error("no power down");
    AST_NO_PD_BURST: assert property (power_down |-> !burst_active)
        else $error("power down in burst");
    AST_REFRESH: assert property (live && cmd == `SDC_CMD_REF
        |=> refresh_column_first == $past(refresh_column_first) + 13'h0001) else $error("refresh");
endmodule // sdc_core_chk

bind sdc_core sdc_core_chk u_sdc_core_chk (.*);
`default_nettype wire

// File: verification/sdc_ctl.sv
`timescale 1ns/1ns
`default_nettype none
`include "sdc_defs.vh"
// ****************
// Controller model
// ****************
module sdc_ctl #(
    parameter PAUSE = 20000
) (
    input  wire logic        sys_clk,
    output var  logic        clock_gate_input,
    output var  logic        select_n_input,
    output var  logic        row_strobe_n,
    output var  logic        col_strobe_n,
    output var  logic        write_strobe_n,
    output var  logic [1:0]  bank_select,
    output var  logic [12:0] addr,
    output var  logic        byte_mask,
    output var  logic [7:0]  ctl_dq
);
    initial begin
        clock_gate_input = 1'h1;
        byte_mask        = 1'h1;
        select_n_input   = 1'h1;
        {row_strobe_n, col_strobe_n, write_strobe_n} = `SDC_CMD_NOP;
        bank_select      = 2'h0;
        addr             = 13'h0000;
        ctl_dq           = 8'h00;
    end
    // Idle data toggles, so a device storing stale data is caught
    task automatic issue(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a,
                         input logic m, input logic [7:0] d, input logic g);
        @(posedge sys_clk);
        clock_gate_input <= g;
        select_n_input   <= 1'h0;
        {row_strobe_n, col_strobe_n, write_strobe_n} <= c;
        bank_select      <= b;
        addr             <= a;
        byte_mask        <= m;
        ctl_dq           <= (c == `SDC_CMD_WR) ? d : ~ctl_dq;
    endtask
    task automatic desel(input logic g);
        @(posedge sys_clk);
        clock_gate_input <= g;
        select_n_input   <= 1'h1;
        ctl_dq           <= ~ctl_dq;
    endtask
    task automatic power_up;
        repeat (PAUSE) @(posedge sys_clk);
        issue(`SDC_CMD_PRE, 2'h0, 13'h0400, 1'h1, 8'h00, 1'h1);
        repeat (8) issue(`SDC_CMD_REF, 2'h0, 13'h0000, 1'h1, 8'h00, 1'h1);
        issue(`SDC_CMD_NOP, 2'h0, 13'h0000, 1'h1, 8'h00, 1'h1);
    endtask
endmodule // sdc_ctl
`default_nettype wire

// File: verification/sdram_command_mode_init_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "sdc_defs.vh"
// ****************
// Top bench
// ****************
module sdram_command_mode_init_tb_top;
    logic        sys_clk, rstn, clock_gate_input, select_n_input;
    logic        row_strobe_n, col_strobe_n, write_strobe_n, byte_mask;
    logic        data_lines_oe, mode_valid, burst_active, power_down, clock_suspend, self_refresh;
    logic [1:0]  bank_select;
    logic [3:0]  bank_open;
    logic [7:0]  ctl_dq, data_lines_in, data_lines_out;
    logic [12:0] addr, mode_fields, refresh_column_first;
    logic [31:0] seed;
    logic [7:0]  mem [0:255];
    logic [12:0] colv [0:7];
    integer      failures = 0, checks_done = 0, cyc = 0, i;

    sdc_core u_sdc_core (.*);
    sdc_ctl  u_sdc_ctl (.*);
    // The device wins the shared data wire only while it drives
    assign data_lines_in = data_lines_oe ? data_lines_out : ctl_dq;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string n, input logic [12:0] s, input logic [12:0] e);
        checks_done = checks_done + 1;
        if (s !== e) begin
            failures = failures + 1;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic nop(input integer k);
        repeat (k) u_sdc_ctl.issue(`SDC_CMD_NOP, seed[1:0], seed[12:0], 1'h0, seed[7:0], 1'h1);
    endtask
    task automatic cmd(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a);
        u_sdc_ctl.issue(c, b, a, 1'h0, seed[7:0], 1'h1);
        nop(1);
        #1;
    endtask
    task automatic wr(input logic [1:0] b, input logic [12:0] a, input logic m, input logic [7:0] d);
        u_sdc_ctl.issue(`SDC_CMD_WR, b, a, m, d, 1'h1);
        if (!m) mem[{b, a[5:0]}] = d;
    endtask
    task automatic rd(input logic [1:0] b, input logic [12:0] a, input logic m, input integer lat);
        u_sdc_ctl.issue(`SDC_CMD_RD, b, a, m, 8'h00, 1'h1);
        nop(2);
        #1 chk("oe2", data_lines_oe, lat == 2 && !m);
        if (lat == 3) begin
            nop(1);
            #1 chk("oe3", data_lines_oe, !m);
        end
        if (!m) chk("data", data_lines_out, mem[{b, a[5:0]}]);
    endtask
    task complete_run;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Init pause alone is 20000 cycles; the rest needs under two hundred
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            failures = failures + 1;
            complete_run;
        end
    end

    initial begin
        rstn = 1'h0;
        seed = 32'h4BDD404C;
        repeat (20) @(posedge sys_clk);
        rstn <= 1'h1;
        repeat (3) u_sdc_ctl.desel(1'h1);
        #1 chk("valid", mode_valid, 1'h0);
        u_sdc_ctl.power_up();
        #1 chk("refs", refresh_column_first, 13'h0008);
        chk("valid", mode_valid, 1'h0);
        for (i = 0; i < 4; i = i + 1) begin
            seed = lfsr(seed);
            cmd(`SDC_CMD_MRS, 2'h0, seed[12:0]);
            chk("mode", mode_fields, seed[12:0]);
            chk("valid", mode_valid, 1'h1);
        end
        cmd(`SDC_CMD_MRS, 2'h0, 13'h0020);
        for (i = 0; i < 4; i = i + 1) begin
            seed = lfsr(seed);
            cmd(`SDC_CMD_ACT, i[1:0], seed[12:0]);
            chk("act", bank_open[i], 1'h1);
        end
        for (i = 0; i < 8; i = i + 1) begin
            seed = lfsr(seed);
            colv[i] = {1'h0, seed[10], 1'h0, seed[9:0]};
            wr(i[1:0], colv[i], 1'h0, seed[23:16]);
        end
        wr(2'h0, colv[0], 1'h1, ~mem[{2'h0, colv[0][5:0]}]);
        for (i = 0; i < 8; i = i + 1) rd(i[1:0], colv[i], i == 6, 2);
        rd(2'h1, colv[1] | 13'h0400, 1'h0, 2);
        nop(2);
        #1 chk("ap", bank_open, 13'h000D);
        cmd(`SDC_CMD_PRE, 2'h3, 13'h0000);
        chk("pre", bank_open, 13'h0005);
        cmd(`SDC_CMD_PRE, 2'h2, 13'h0400);
        chk("preall", bank_open, 13'h0000);
        cmd(`SDC_CMD_MRS, 2'h0, 13'h0033);
        cmd(`SDC_CMD_ACT, 2'h0, 13'h0000);
        rd(2'h0, colv[0], 1'h0, 3);
        u_sdc_ctl.desel(1'h0);
        u_sdc_ctl.desel(1'h0);
        #1 chk("susp", clock_suspend, 1'h1);
        chk("pd", power_down, 1'h0);
        u_sdc_ctl.desel(1'h1);
        nop(12);
        #1 chk("resume", clock_suspend, 1'h0);
        cmd(`SDC_CMD_PRE, 2'h0, 13'h0400);
        u_sdc_ctl.desel(1'h0);
        u_sdc_ctl.desel(1'h0);
        #1 chk("pd", power_down, 1'h1);
        u_sdc_ctl.desel(1'h1);
        nop(2);
        #1 chk("pdx", power_down, 1'h0);
        u_sdc_ctl.issue(`SDC_CMD_REF, 2'h0, 13'h0000, 1'h0, 8'h00, 1'h0);
        u_sdc_ctl.desel(1'h0);
        #1 chk("sref", self_refresh, 1'h1);
        chk("refs", refresh_column_first, 13'h0009);
        u_sdc_ctl.desel(1'h1);
        nop(2);
        #1 chk("srx", self_refresh, 1'h0);
        chk("keep", mode_fields, 13'h0033);
        cmd(`SDC_CMD_MRS, 2'h0, 13'h00A2);
        cmd(`SDC_CMD_ACT, 2'h1, 13'h0000);
        wr(2'h1, 13'h0004, 1'h0, 8'h5A);
        nop(1);
        #1 chk("single", burst_active, 1'h0);
        rd(2'h1, 13'h0004, 1'h0, 2);
        chk("burst", burst_active, 1'h1);
        complete_run;
    end
endmodule // sdram_command_mode_init_tb_top
`default_nettype wire
